// ---- rrlpc_ctrl_props.sv ----
// concurrent checks on the ports of the reclocker control bank
`timescale 1ns/1ns
module rrlpc_ctrl_props (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // analog status and controls
  input wire logic        adaptDone,
  input wire logic        carrierPresentIndicator,
  input wire logic        primaryCableInputSelected,
  input wire logic        lockPinActive,
  input wire logic        primarySleep,
  input wire logic        eqPageReset,
  input wire logic        irq
);
  // ==========================================================
  // one clock domain, reset disables every check
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================
  // bus timing and control outputs
  lock_follow_a: assert property (adaptDone == carrierPresentIndicator |=> lockPinActive == $past(adaptDone))
    else $error("lock pin does not follow its source");
  unused_sleep_a: assert property (!primaryCableInputSelected |=> primarySleep)
    else $error("unused input not in power save");
  srst_pulse_a: assert property (eqPageReset |=> !eqPageReset)
    else $error("page reset pulse longer than one cycle");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held too long");
  bresp_taken_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stays after being taken");
  rresp_taken_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stays after being taken");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");

  // main scenarios reached
  cover property (eqPageReset);
  cover property ($rose(irq));
  cover property (primarySleep && primaryCableInputSelected);
endmodule // rrlpc_ctrl_props

bind rrlpc_reclocker_ctrl rrlpc_ctrl_props rrlpc_ctrl_props_i (.mclk(mclk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .adaptDone(adaptDone), .carrierPresentIndicator(carrierPresentIndicator),
  .primaryCableInputSelected(primaryCableInputSelected), .lockPinActive(lockPinActive),
  .primarySleep(primarySleep), .eqPageReset(eqPageReset), .irq(irq));

// ---- rrlpc_defines.vh ----
// register map, field positions and reset values of the rate-lock and power control bank
`ifndef RRLPC_DEFINES_VH
`define RRLPC_DEFINES_VH
// word indices of the reclocker page; the byte address is four times the index
`define RRLPC_IDX_RSV94     8'h94
`define RRLPC_IDX_RSV95     8'h95
`define RRLPC_IDX_RSV98     8'h98
`define RRLPC_IDX_RSV99     8'h99
`define RRLPC_IDX_RSV9A     8'h9A
`define RRLPC_IDX_RSV9B     8'h9B
`define RRLPC_IDX_RSV9C     8'h9C
`define RRLPC_IDX_RSV9D     8'h9D
`define RRLPC_IDX_RSV9E     8'h9E
`define RRLPC_IDX_RATE      8'hA0
// equalizer/driver page control index, and byte addresses of the indexed words
`define RRLPC_IDX_CTRL      8'h00
`define RRLPC_ADDR_CTRL     {2'h0, `RRLPC_IDX_CTRL, 2'h0}
`define RRLPC_ADDR_RATE     {2'h0, `RRLPC_IDX_RATE, 2'h0}
// interrupt status and mask
`define RRLPC_ADDR_IRQSTAT  12'h110
`define RRLPC_ADDR_IRQMASK  12'h114
// reset values
`define RRLPC_RST_RSV94     8'h37
`define RRLPC_RST_RSV95     8'h3E
`define RRLPC_RST_RSV98     8'h3F
`define RRLPC_RST_RSV99     8'h04
`define RRLPC_RST_RSV9A     8'h04
`define RRLPC_RST_RSV9B     8'h04
`define RRLPC_RST_RSV9C     8'h06
`define RRLPC_RST_RSV9D     8'h04
`define RRLPC_RST_RSV9E     8'h04
`define RRLPC_RST_RATE      5'h1F
`define RRLPC_RST_CTRL      8'h08
`define RRLPC_RST_PS        2'h1
// control field positions
`define RRLPC_CTRL_LOCKSEL  7
`define RRLPC_CTRL_OVR      5
`define RRLPC_CTRL_PS_HI    4
`define RRLPC_CTRL_PS_LO    3
`define RRLPC_CTRL_SRST     2
// power-save field codes
`define RRLPC_PS_AUTO       2'h0
`define RRLPC_PS_NEVER      2'h1
`define RRLPC_PS_RSVD       2'h2
`define RRLPC_PS_FORCE      2'h3
// interrupt status bits
`define RRLPC_IRQ_SRST      0
`define RRLPC_IRQ_SLEEP     1
`define RRLPC_IRQ_LOCKPIN   2
`define RRLPC_IRQ_W         3
// bus answers
`define RRLPC_RESP_OKAY     2'h0
`define RRLPC_RESP_SLVERR   2'h2
`endif

// ---- rrlpc_reclocker_ctrl.v ----
// rate-lock enables, lock pin source, power save and page soft reset behind an AXI4-Lite slave
`timescale 1ns/1ns
`include "rrlpc_defines.vh"

module rrlpc_reclocker_ctrl (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // analog status from the primary cable input
  input  wire        adaptDone,
  input  wire        carrierPresentIndicator,
  input  wire        primaryCableInputSelected,
  // controls to the recovery loop and equalizer
  output reg  [4:0]  rateLockAllow,
  output reg         lockPinActive,
  output reg         primarySleep,
  output reg         eqPageReset,
  // interrupt
  output reg         irq
);

  // ===========================================================================
  // register state
  reg [4:0]  rateLock_r;
  reg        lockSel_r;
  reg        sleepOvr_r;
  reg [1:0]  sleepPol_r;
  reg [7:0]  rsv94_r;
  reg [7:0]  rsv95_r;
  reg [7:0]  rsv98_r;
  reg [7:0]  rsv99_r;
  reg [7:0]  rsv9A_r;
  reg [7:0]  rsv9B_r;
  reg [7:0]  rsv9C_r;
  reg [7:0]  rsv9D_r;
  reg [7:0]  rsv9E_r;
  reg [`RRLPC_IRQ_W-1:0] irqStat_r;
  reg [`RRLPC_IRQ_W-1:0] irqMask_r;
  reg        lockPinPrev_r;
  reg        sleepPrev_r;

  // ===========================================================================
  // write channel capture, address and data accepted in either order
  reg        awHave_r;
  reg [11:0] awAddr_r;
  reg        wHave_r;
  reg [31:0] wData_r;
  reg        wLane_r;
  wire       doWrite = awHave_r & wHave_r & ~s_axi_bvalid;
  wire       wrCtrl  = doWrite & wLane_r & (awAddr_r == `RRLPC_ADDR_CTRL);
  wire       wrRate  = doWrite & wLane_r & (awAddr_r == `RRLPC_ADDR_RATE);
  wire       wrMask  = doWrite & wLane_r & (awAddr_r == `RRLPC_ADDR_IRQMASK);
  wire       srstReq = wrCtrl & wData_r[`RRLPC_CTRL_SRST];

  // write address ready pulse and holding
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHave_r      <= 1'b0;
      awAddr_r      <= 12'h000;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= ~awHave_r & ~s_axi_awready & s_axi_awvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (doWrite)
        awHave_r <= 1'b0; // address used up by the response
    end
  end

  // write data ready pulse and holding
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wHave_r      <= 1'b0;
      wData_r      <= 32'h00000000;
      wLane_r      <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= ~wHave_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_wvalid & s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wLane_r <= s_axi_wstrb[0]; // registers sit in byte lane 0
      end
      if (doWrite)
        wHave_r <= 1'b0; // data used up by the response
    end
  end

  // write response once both halves are held
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RRLPC_RESP_OKAY;
    end else begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr_r) ? `RRLPC_RESP_OKAY : `RRLPC_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // decode of every mapped word
  function mapped;
    input [11:0] a;
    begin
      if (a == `RRLPC_ADDR_RATE)
        mapped = 1'b1;
      else if (a == `RRLPC_ADDR_CTRL)
        mapped = 1'b1;
      else if (a == `RRLPC_ADDR_IRQSTAT)
        mapped = 1'b1;
      else if (a == `RRLPC_ADDR_IRQMASK)
        mapped = 1'b1;
      else if ((a[11:10] == 2'h0) && (a[1:0] == 2'h0) && (a[9:2] >= `RRLPC_IDX_RSV94) && (a[9:2] <= `RRLPC_IDX_RSV9E))
        mapped = (a[9:2] != 8'h96) && (a[9:2] != 8'h97); // gaps in the reserved run
      else
        mapped = 1'b0;
    end
  endfunction

  // ===========================================================================
  // page control fields; the soft reset restores the page reset image
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      lockSel_r  <= 1'b0;
      sleepOvr_r <= 1'b0;
      sleepPol_r <= `RRLPC_RST_PS;
    end else if (srstReq) begin
      lockSel_r  <= 1'b0;
      sleepOvr_r <= 1'b0;
      sleepPol_r <= `RRLPC_RST_PS;
    end else if (wrCtrl) begin
      lockSel_r  <= wData_r[`RRLPC_CTRL_LOCKSEL];
      sleepOvr_r <= wData_r[`RRLPC_CTRL_OVR];
      sleepPol_r <= wData_r[`RRLPC_CTRL_PS_HI:`RRLPC_CTRL_PS_LO];
    end
  end

  // rate-lock enables live on the other page and ignore the soft reset
  always @(posedge mclk or posedge rst) begin
    if (rst)
      rateLock_r <= `RRLPC_RST_RATE;
    else if (wrRate)
      rateLock_r <= wData_r[4:0]; // bits 7:5 are reserved and stay zero
  end

  // interrupt mask
  always @(posedge mclk or posedge rst) begin
    if (rst)
      irqMask_r <= {`RRLPC_IRQ_W{1'b0}};
    else if (wrMask)
      irqMask_r <= wData_r[`RRLPC_IRQ_W-1:0];
  end

  // reserved words hold their reset values; writes are ignored
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsv94_r <= `RRLPC_RST_RSV94;
      rsv95_r <= `RRLPC_RST_RSV95;
      rsv98_r <= `RRLPC_RST_RSV98;
      rsv99_r <= `RRLPC_RST_RSV99;
      rsv9A_r <= `RRLPC_RST_RSV9A;
      rsv9B_r <= `RRLPC_RST_RSV9B;
      rsv9C_r <= `RRLPC_RST_RSV9C;
      rsv9D_r <= `RRLPC_RST_RSV9D;
      rsv9E_r <= `RRLPC_RST_RSV9E;
    end else begin
      rsv94_r <= rsv94_r;
      rsv95_r <= rsv95_r;
      rsv98_r <= rsv98_r;
      rsv99_r <= rsv99_r;
      rsv9A_r <= rsv9A_r;
      rsv9B_r <= rsv9B_r;
      rsv9C_r <= rsv9C_r;
      rsv9D_r <= rsv9D_r;
      rsv9E_r <= rsv9E_r;
    end
  end

  // ===========================================================================
  // power save decision
  reg sleepNxt;
  always @* begin
    sleepNxt = ~carrierPresentIndicator;
    if (sleepOvr_r) begin
      case (sleepPol_r)
        `RRLPC_PS_AUTO:  sleepNxt = ~carrierPresentIndicator;
        `RRLPC_PS_NEVER: sleepNxt = 1'b0;
        `RRLPC_PS_FORCE: sleepNxt = 1'b1;
        default:         sleepNxt = ~carrierPresentIndicator; // reserved code acts as auto
      endcase
    end
    if (~primaryCableInputSelected)
      sleepNxt = 1'b1;
  end

  // lock pin source
  wire lockPinNxt = lockSel_r ? carrierPresentIndicator : adaptDone;

  // ===========================================================================
  // outputs to the analog side
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rateLockAllow <= `RRLPC_RST_RATE;
      lockPinActive <= 1'b0;
      primarySleep  <= 1'b0;
      eqPageReset   <= 1'b0;
    end else begin
      rateLockAllow <= rateLock_r;
      lockPinActive <= lockPinNxt;
      primarySleep  <= sleepNxt;
      eqPageReset   <= srstReq;
    end
  end

  // previous output levels for edge detection, matching their reset levels
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      lockPinPrev_r <= 1'b0;
      sleepPrev_r   <= 1'b0;
    end else begin
      lockPinPrev_r <= lockPinActive;
      sleepPrev_r   <= primarySleep;
    end
  end

  // ===========================================================================
  // read channel
  wire       rdStat = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `RRLPC_ADDR_IRQSTAT);
  reg  [7:0] rdByte;
  always @* begin
    rdByte = 8'h00;
    if (s_axi_araddr == `RRLPC_ADDR_RATE)
      rdByte = {3'h0, rateLock_r};
    else if (s_axi_araddr == `RRLPC_ADDR_CTRL)
      rdByte = {lockSel_r, 1'b0, sleepOvr_r, sleepPol_r, 3'h0};
    else if (s_axi_araddr == `RRLPC_ADDR_IRQSTAT)
      rdByte = {5'h00, irqStat_r};
    else if (s_axi_araddr == `RRLPC_ADDR_IRQMASK)
      rdByte = {5'h00, irqMask_r};
    else if (s_axi_araddr == {2'h0, `RRLPC_IDX_RSV94, 2'h0})
      rdByte = rsv94_r;
    else if (s_axi_araddr == {2'h0, `RRLPC_IDX_RSV95, 2'h0})
      rdByte = rsv95_r;
    else if (s_axi_araddr == {2'h0, `RRLPC_IDX_RSV98, 2'h0})
      rdByte = rsv98_r;
    else if (s_axi_araddr == {2'h0, `RRLPC_IDX_RSV99, 2'h0})
      rdByte = rsv99_r;
    else if (s_axi_araddr == {2'h0, `RRLPC_IDX_RSV9A, 2'h0})
      rdByte = rsv9A_r;
    else if (s_axi_araddr == {2'h0, `RRLPC_IDX_RSV9B, 2'h0})
      rdByte = rsv9B_r;
    else if (s_axi_araddr == {2'h0, `RRLPC_IDX_RSV9C, 2'h0})
      rdByte = rsv9C_r;
    else if (s_axi_araddr == {2'h0, `RRLPC_IDX_RSV9D, 2'h0})
      rdByte = rsv9D_r;
    else if (s_axi_araddr == {2'h0, `RRLPC_IDX_RSV9E, 2'h0})
      rdByte = rsv9E_r;
  end

  // read address ready pulse, refused while read data waits
  always @(posedge mclk or posedge rst) begin
    if (rst)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
  end

  // read data return
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RRLPC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rdByte};
        s_axi_rresp  <= mapped(s_axi_araddr) ? `RRLPC_RESP_OKAY : `RRLPC_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // sticky events, cleared by a status read; a new event wins over the clear
  wire                    lockPinChange = lockPinActive ^ lockPinPrev_r;
  wire                    sleepEntry    = primarySleep & ~sleepPrev_r;
  wire [`RRLPC_IRQ_W-1:0] evt           = {lockPinChange, sleepEntry, eqPageReset};
  wire [`RRLPC_IRQ_W-1:0] statKept      = rdStat ? {`RRLPC_IRQ_W{1'b0}} : irqStat_r;
  wire [`RRLPC_IRQ_W-1:0] statNxt       = statKept | evt;

  // status register and level interrupt
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqStat_r <= {`RRLPC_IRQ_W{1'b0}};
      irq       <= 1'b0;
    end else begin
      irqStat_r <= statNxt;
      irq       <= |(statNxt & irqMask_r);
    end
  end

endmodule // rrlpc_reclocker_ctrl

// ---- tb_top.sv ----
// self-checking bench for the reclocker control bank
`timescale 1ns/1ns
`include "rrlpc_defines.vh"
module tb_top;
  // ==========================================================
  // design ports and bench state
  logic        mclk, rst;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        adaptDone, carrierPresentIndicator, primaryCableInputSelected;
  logic [4:0]  rateLockAllow;
  logic        lockPinActive, primarySleep, eqPageReset, irq;
  int          n_fail, comparisons, cycles, pulses;
  // reserved words and their reset images
  logic [11:0] rsvAddr [9] = '{12'h250, 12'h254, 12'h260, 12'h264, 12'h268, 12'h26C, 12'h270, 12'h274, 12'h278};
  logic [7:0]  rsvVal [9]  = '{8'h37, 8'h3E, 8'h3F, 8'h04, 8'h04, 8'h04, 8'h06, 8'h04, 8'h04};
  // power rows: control byte, carrier, input used, expected sleep
  logic [10:0] pwrTab [7]  = '{11'h003, 11'h006, 11'h103, 11'h142, 11'h1C7, 11'h186, 11'h141};

  rrlpc_reclocker_ctrl rrlpc_reclocker_ctrl_i (.mclk(mclk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .adaptDone(adaptDone), .carrierPresentIndicator(carrierPresentIndicator),
    .primaryCableInputSelected(primaryCableInputSelected), .rateLockAllow(rateLockAllow),
    .lockPinActive(lockPinActive), .primarySleep(primarySleep), .eqPageReset(eqPageReset), .irq(irq));

  // ==========================================================
  // clock, hang limit and page reset pulse counter
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (eqPageReset === 1'b1) pulses <= pulses + 1;
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end

  // ==========================================================
  // comparison, bus tasks and closing report
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rdw(input logic [11:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task tResetValues;
    chk(rateLockAllow, 32'h1F);
    rdw(`RRLPC_ADDR_RATE); chk(rd, 32'h1F);
    rdw(`RRLPC_ADDR_CTRL); chk(rd, 32'h08);
    for (int i = 0; i < 9; i++) begin
      rdw(rsvAddr[i]); chk(rd, {24'h000000, rsvVal[i]});
      chk(rsp, `RRLPC_RESP_OKAY);
    end
    wr(12'h250, 8'hFF); rdw(12'h250); chk(rd, 32'h37);
  endtask
  task tRate;
    for (int i = 0; i < 5; i++) begin
      wr(`RRLPC_ADDR_RATE, 8'h1F ^ (8'h01 << i)); idle(2); chk(rateLockAllow, 32'h1F ^ (32'h01 << i));
      rdw(`RRLPC_ADDR_RATE); chk(rd, 32'h1F ^ (32'h01 << i));
    end
    wr(`RRLPC_ADDR_RATE, 8'hFF); rdw(`RRLPC_ADDR_RATE); chk(rd, 32'h1F);
  endtask
  task tLockPin;
    adaptDone <= 1'b1;
    carrierPresentIndicator <= 1'b0;
    wr(`RRLPC_ADDR_CTRL, 8'h00); idle(2); chk(lockPinActive, 32'h1);
    wr(`RRLPC_ADDR_CTRL, 8'h80); idle(2); chk(lockPinActive, 32'h0);
    carrierPresentIndicator <= 1'b1; idle(2); chk(lockPinActive, 32'h1);
  endtask
  task tPower;
    for (int i = 0; i < 7; i++) begin
      carrierPresentIndicator <= pwrTab[i][2];
      primaryCableInputSelected <= pwrTab[i][1];
      wr(`RRLPC_ADDR_CTRL, pwrTab[i][10:3]); idle(2); chk(primarySleep, pwrTab[i][0]);
      rdw(`RRLPC_ADDR_CTRL); chk(rd, {24'h000000, pwrTab[i][10:3]});
    end
    primaryCableInputSelected <= 1'b1;
  endtask
  task tSoftReset;
    int n;
    wr(`RRLPC_ADDR_IRQMASK, 8'h00); wr(`RRLPC_ADDR_RATE, 8'h15); rdw(`RRLPC_ADDR_IRQSTAT);
    n = pulses;
    wr(`RRLPC_ADDR_CTRL, 8'hAC); idle(3); chk(pulses - n, 32'h1);
    chk(irq, 32'h0);
    rdw(`RRLPC_ADDR_CTRL); chk(rd, 32'h08);
    wr(`RRLPC_ADDR_CTRL, 8'h08); chk(rsp, `RRLPC_RESP_OKAY);
    chk(rateLockAllow, 32'h15);
    wr(`RRLPC_ADDR_IRQMASK, 8'h01); idle(2); chk(irq, 32'h1);
    rdw(`RRLPC_ADDR_IRQSTAT); chk(rd[0], 32'h1); idle(2); chk(irq, 32'h0);
  endtask
  task tUnmapped;
    rdw(12'h200); chk(rsp, `RRLPC_RESP_SLVERR); chk(rd, 32'h0);
    rdw(12'h258); chk(rsp, `RRLPC_RESP_SLVERR);
    wr(12'h204, 8'h55); chk(rsp, `RRLPC_RESP_SLVERR);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h1;
    adaptDone = 1'b0;
    carrierPresentIndicator = 1'b0;
    primaryCableInputSelected = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    tResetValues;
    tRate;
    tLockPin;
    tPower;
    tSoftReset;
    tUnmapped;
    summarize();
  end
endmodule // tb_top
